// >>> src/osw_device.sv
// Device end of the octal switch serial control port.
// Assumes a master that keeps sclk low around every chip select edge.
//
// What this block does
// - Shift and drive only while chip select low
// - Chip select rise latches word into switches
// - Chip select fall loads drain status
// - Chip select low enables serial output driver
// - Input bit captured on sclk falling edge
// - Output bit changes on sclk rising edge
// - Master keeps sclk low at select edges
// - Master should keep sclk low while deselected
// - Deselected: ignore inputs, serial output released
// - Command bit low turns switch on
// - Command word is eight bits, one per output
// - One bit each way per sclk cycle
// - Status returned during the command transfer
// - Output 7 first, output 0 last
// - Status high when off, low when on
// - Reset switches off; clears shift register only while sclk runs
// - Shift register full after eight bits
`timescale 1ns/1ps
`include "osw_regs.svh"

module osw_device (
  input  wire logic                 clock,
  input  wire logic                 rst,
  osw_link_if.dev                   link,
  input  wire osw_pkg::osw_word_type drainHigh,
  output osw_pkg::osw_word_type     switchOn
);
  // System domain state: select and clock edges, first-edge flags,
  // status snapshot and switch latch
  typedef struct packed {
    logic                  csPrev;
    logic                  sclkPrev;
    logic                  noRise;
    logic                  noFall;
    osw_pkg::osw_word_type statusSnap;
    osw_pkg::osw_word_type switchOn;
  } osw_dev_sys_type;

  // Link domain state taken on sclk falling edges
  typedef struct packed {
    osw_pkg::osw_word_type shift;
  } osw_dev_fall_type;

  // Link domain state taken on sclk rising edges
  typedef struct packed {
    logic soBit;
  } osw_dev_rise_type;

  osw_dev_sys_type  sys_reg;
  osw_dev_sys_type  sys_next;
  osw_dev_fall_type fall_reg;
  osw_dev_fall_type fall_next;
  osw_dev_rise_type rise_reg;
  osw_dev_rise_type rise_next;

  logic                  csSync;
  osw_pkg::osw_word_type drainSync;
  logic                  rstLink;
  logic                  sclkSync;
  logic                  csRise;
  logic                  csFall;
  logic                  sclkRise;
  logic                  sclkFall;

  // ==========================================================
  // Synchronisers into the system domain
  // Chip select and drain levels are pins, so both pass two stages.
  osw_sync2 #(
    .W    (1),
    .INIT (1'b1)
  ) u_cs_sync (
    .clock (clock),
    .rst   (rst),
    .din   (link.csN),
    .dout  (csSync)
  );

  osw_sync2 #(
    .W    (`OSW_WORD_BITS),
    .INIT (`OSW_STATUS_RST)
  ) u_drain_sync (
    .clock (clock),
    .rst   (rst),
    .din   (drainHigh),
    .dout  (drainSync)
  );

  // Serial clock seen from the system side, to find the first edges
  osw_sync2 #(
    .W    (1),
    .INIT (1'b0)
  ) u_sclk_sync (
    .clock (clock),
    .rst   (rst),
    .din   (link.sclk),
    .dout  (sclkSync)
  );

  // Reset carried into the link domain; acts only while sclk runs,
  // the first-edge flags keep stale link contents unused meanwhile.
  osw_sync2 #(
    .W    (1),
    .INIT (1'b1)
  ) u_rst_sync (
    .clock (link.sclk),
    .rst   (1'b0),
    .din   (rst),
    .dout  (rstLink)
  );

  // ==========================================================
  // System domain: select edges
  assign csRise = csSync & ~sys_reg.csPrev;
  assign csFall = ~csSync & sys_reg.csPrev;
  assign sclkRise = sclkSync & ~sys_reg.sclkPrev;
  assign sclkFall = ~sclkSync & sys_reg.sclkPrev;

  // First-edge flags tell the link side which edge opens the frame.
  // They move a few clocks after an sclk edge and then hold for most
  // of a half period, so the link side reads them as settled levels.
  always_comb begin
    sys_next          = sys_reg;
    sys_next.csPrev   = csSync;
    sys_next.sclkPrev = sclkSync;
    if (csFall) begin
      sys_next.statusSnap = drainSync;
    end
    // Deselected: sclk is ignored and both flags rearm for next frame
    if (csSync) begin
      sys_next.noRise = 1'b1;
      sys_next.noFall = 1'b1;
    end else begin
      if (sclkRise) begin
        sys_next.noRise = 1'b0;
      end
      if (sclkFall) begin
        sys_next.noFall = 1'b0;
      end
    end
    // Sclk is parked low at the rise, so the shift word is quiet here.
    // A frame with no clocks leaves the switches as they were.
    if (csRise && !sys_reg.noFall) begin
      sys_next.switchOn = ~fall_reg.shift;
    end
    if (rst) begin
      sys_next.csPrev     = 1'b1;
      sys_next.sclkPrev   = 1'b0;
      sys_next.noRise     = 1'b1;
      sys_next.noFall     = 1'b1;
      sys_next.statusSnap = `OSW_STATUS_RST;
      sys_next.switchOn   = `OSW_SWITCH_RST;
    end
  end

  always_ff @(posedge clock) begin
    sys_reg <= sys_next;
  end

  assign switchOn = sys_reg.switchOn;

  // ==========================================================
  // Link domain, falling edge: capture
  // The first capture of a frame takes the status word in place of
  // the old contents, so status leaves in the same transfer. The
  // flag read here settled many system clocks before this edge.
  always_comb begin
    fall_next = fall_reg;
    if (!link.csN) begin
      if (sys_reg.noFall) begin
        fall_next.shift = {sys_reg.statusSnap[`OSW_MSB-1:0], link.mosi};
      end else begin
        fall_next.shift = {fall_reg.shift[`OSW_MSB-1:0], link.mosi};
      end
    end
    if (rstLink) begin
      fall_next.shift = '0;
    end
  end

  always_ff @(negedge link.sclk) begin
    fall_reg <= fall_next;
  end

  // ==========================================================
  // Link domain, rising edge: present next bit
  // Bit 7 of the captured word goes out each rise after the first; after eight bits
  // that is the oldest command bit, which feeds a chained device.
  always_comb begin
    rise_next = rise_reg;
    if (!link.csN) begin
      if (sys_reg.noRise) begin
        rise_next.soBit = sys_reg.statusSnap[`OSW_MSB];
      end else begin
        rise_next.soBit = fall_reg.shift[`OSW_MSB];
      end
    end
    if (rstLink) begin
      rise_next.soBit = 1'b0;
    end
  end

  always_ff @(posedge link.sclk) begin
    rise_reg <= rise_next;
  end

  // ==========================================================
  // Serial output and its driver
  // Until the first rise, output 7 status shows straight from the
  // snapshot; the enable follows the pin with no clock at all.
  assign link.miso   = sys_reg.noRise ? sys_reg.statusSnap[`OSW_MSB] : rise_reg.soBit;
  assign link.misoOe = ~link.csN;
endmodule

// >>> src/osw_host.sv
// Master end: sends one command word and collects the status word.
// Assumes the device end sits on the other side of the link interface.
`timescale 1ns/1ps
`include "osw_regs.svh"

module osw_host #(
  parameter int NBITS    = `OSW_WORD_BITS,
  parameter int HALF_CYC = `OSW_HALF_CYC,
  parameter int LEAD_CYC = `OSW_LEAD_CYC
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [NBITS-1:0] cmdOn,
  output logic                  busy,
  output logic                  done,
  output logic      [NBITS-1:0] statusHigh,
  osw_link_if.host              link
);
  // ==========================================================
  // Parameter limits: counts live in eight bits, the index in seven,
  // and the device end needs a few system clocks per half period.
  if (NBITS < 8 || NBITS % `OSW_WORD_BITS != 0 || NBITS > 64 || HALF_CYC < 4 ||
      HALF_CYC > 255 || LEAD_CYC < 4 || LEAD_CYC > 255) begin : g_param_check
    $error("osw_host: unsupported parameter values");
  end

  typedef struct packed {
    osw_pkg::osw_host_state_type state;
    logic [7:0]                  cnt;
    logic [6:0]                  bitIdx;
    logic [NBITS-1:0]            txShift;
    logic [NBITS-1:0]            rxShift;
    logic [NBITS-1:0]            status;
    logic                        csN;
    logic                        sclk;
    logic                        mosi;
    logic                        done;
  } osw_host_st_type;

  osw_host_st_type h_reg;
  osw_host_st_type h_next;
  logic            misoSync;

  // ==========================================================
  // Status line comes back across the pins
  osw_sync2 #(
    .W    (1),
    .INIT (1'b1)
  ) u_miso_sync (
    .clock (clock),
    .rst   (rst),
    .din   (link.misoLine),
    .dout  (misoSync)
  );

  // ==========================================================
  // Sequencer: sclk made by dividing the system clock
  // Sclk only moves while chip select is steady low.
  always_comb begin
    h_next      = h_reg;
    h_next.done = 1'b0;
    if (h_reg.cnt != 8'h00) begin
      h_next.cnt = h_reg.cnt - 8'h01;
    end
    case (h_reg.state)
      osw_pkg::HOST_IDLE: begin
        if (start) begin
          h_next.txShift = ~cmdOn;
          h_next.mosi    = ~cmdOn[NBITS-1];
          h_next.csN     = 1'b0;
          h_next.bitIdx  = '0;
          h_next.cnt     = 8'(LEAD_CYC - 1);
          h_next.state   = osw_pkg::HOST_LEAD;
        end
      end
      osw_pkg::HOST_LEAD: begin
        if (h_reg.cnt == 8'h00) begin
          h_next.sclk  = 1'b1;
          h_next.cnt   = 8'(HALF_CYC - 1);
          h_next.state = osw_pkg::HOST_HIGH;
        end
      end
      osw_pkg::HOST_HIGH: begin
        // Sample late in the high half, long after the device moved it
        if (h_reg.cnt == 8'h00) begin
          h_next.rxShift = {h_reg.rxShift[NBITS-2:0], misoSync};
          h_next.txShift = {h_reg.txShift[NBITS-2:0], 1'b0};
          h_next.sclk    = 1'b0;
          h_next.cnt     = 8'(HALF_CYC - 1);
          h_next.state   = osw_pkg::HOST_LOW;
        end
      end
      osw_pkg::HOST_LOW: begin
        if (h_reg.cnt == 8'h00) begin
          if (h_reg.bitIdx == 7'(NBITS - 1)) begin
            h_next.cnt   = 8'(LEAD_CYC - 1);
            h_next.state = osw_pkg::HOST_LAG;
          end else begin
            h_next.bitIdx = h_reg.bitIdx + 7'h01;
            h_next.mosi   = h_reg.txShift[NBITS-1];
            h_next.sclk   = 1'b1;
            h_next.cnt    = 8'(HALF_CYC - 1);
            h_next.state  = osw_pkg::HOST_HIGH;
          end
        end
      end
      osw_pkg::HOST_LAG: begin
        if (h_reg.cnt == 8'h00) begin
          h_next.csN    = 1'b1;
          h_next.status = h_reg.rxShift;
          h_next.done   = 1'b1;
          h_next.cnt    = 8'(LEAD_CYC - 1);
          h_next.state  = osw_pkg::HOST_GAP;
        end
      end
      osw_pkg::HOST_GAP: begin
        if (h_reg.cnt == 8'h00) begin
          h_next.state = osw_pkg::HOST_IDLE;
        end
      end
      default: begin
        h_next.state = osw_pkg::HOST_IDLE;
      end
    endcase
    if (rst) begin
      h_next         = '0;
      h_next.state   = osw_pkg::HOST_IDLE;
      h_next.csN     = 1'b1;
      h_next.status  = '1;
    end
  end

  always_ff @(posedge clock) begin
    h_reg <= h_next;
  end

  assign busy       = (h_reg.state != osw_pkg::HOST_IDLE);
  assign done       = h_reg.done;
  assign statusHigh = h_reg.status;
  assign link.csN   = h_reg.csN;
  assign link.sclk  = h_reg.sclk;
  assign link.mosi  = h_reg.mosi;
endmodule

// >>> src/osw_link_if.sv
// Serial link between the controlling master and the octal switch.
// Assumes the device drives its serial output only with the enable high.
`timescale 1ns/1ps

interface osw_link_if;
  logic csN;       // Chip select, active low
  logic sclk;      // Serial clock, made by the master
  logic mosi;      // Command bits toward the device
  logic miso;      // Status bit driven by the device
  logic misoOe;    // Device drives miso while high
  logic misoLine;  // Resolved level of the shared wire

  // ==========================================================
  // Wire resolution; no pull on the line, so a released wire shows
  // the inverse of the last bit and any late sample stands out.
  assign misoLine = misoOe ? miso : ~miso;

  modport dev (
    input  csN,
    input  sclk,
    input  mosi,
    output miso,
    output misoOe
  );

  modport host (
    output csN,
    output sclk,
    output mosi,
    input  misoLine
  );
endinterface

// >>> src/osw_pkg.sv
// Types shared by both ends of the octal switch serial control port.
// Assumes nothing of its surroundings.
package osw_pkg;

  // Host sequencer states, one-hot
  typedef enum logic [5:0] {
    HOST_IDLE = 6'h01,
    HOST_LEAD = 6'h02,
    HOST_HIGH = 6'h04,
    HOST_LOW  = 6'h08,
    HOST_LAG  = 6'h10,
    HOST_GAP  = 6'h20
  } osw_host_state_type;

  typedef logic [7:0] osw_word_type;

endpackage

// >>> src/osw_regs.svh
// Timing and layout constants of the octal switch serial control port.
// Assumes inclusion by bare name from design files of this block only.
`ifndef OSW_REGS_SVH
`define OSW_REGS_SVH

// Word layout: one bit per output switch, first bit out is output 7
`define OSW_WORD_BITS    8
`define OSW_MSB          7
// Reset values: command latch all off, status snapshot reads as off
`define OSW_SWITCH_RST   8'h00
`define OSW_STATUS_RST   8'hFF
// System clock period and least serial clock half period, in ns
`define OSW_CLK_NS       10
`define OSW_SCLK_HALF_NS 250
// Least chip select lead and lag, in ns
`define OSW_LEAD_NS      250
// Cycle counts, least times rounded up
`define OSW_HALF_CYC     ((`OSW_SCLK_HALF_NS + `OSW_CLK_NS - 1) / `OSW_CLK_NS)
`define OSW_LEAD_CYC     ((`OSW_LEAD_NS + `OSW_CLK_NS - 1) / `OSW_CLK_NS)

`endif

// >>> src/osw_sync2.sv
// Two flip-flop synchroniser for a group of levels.
// Assumes each bit changes independently or is held stable by protocol.
`timescale 1ns/1ps

module osw_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // Refuse a width that leaves no bits to carry
  if (W < 1) begin : g_width_check
    $error("osw_sync2: width must be at least one");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } osw_sync_type;

  osw_sync_type s_reg;
  osw_sync_type s_next;

  // ==========================================================
  // Two stages; only the second stage is read outside
  always_comb begin
    s_next.meta = din;
    s_next.held = s_reg.meta;
    if (rst) begin
      s_next.meta = INIT;
      s_next.held = INIT;
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  assign dout = s_reg.held;
endmodule

// >>> verification/octal_switch_serial_control_test.sv
// Self-checking bench: host and device joined by the link interface.
// Assumes the design files of the block are compiled first.
`timescale 1ns/1ps

module octal_switch_serial_control_test;
  logic                  clock      = 1'b0;
  logic                  rst        = 1'b1;
  logic                  start      = 1'b0;
  logic                  start2     = 1'b0;
  osw_pkg::osw_word_type cmdOn      = 8'h00;
  osw_pkg::osw_word_type drainHigh  = 8'hFF;
  logic [15:0]           cmdOn2     = 16'h0000;
  osw_pkg::osw_word_type mosiBits   = 8'h00;
  osw_pkg::osw_word_type misoBits   = 8'h00;
  osw_pkg::osw_word_type cmdTab[4]   = '{8'h00, 8'hFF, 8'hA5, 8'h3C};
  osw_pkg::osw_word_type drainTab[4] = '{8'hFF, 8'h00, 8'h5A, 8'h81};
  logic                  busy;
  logic                  done;
  logic                  busy2;
  logic                  done2;
  osw_pkg::osw_word_type statusHigh;
  osw_pkg::osw_word_type switchOn;
  osw_pkg::osw_word_type switchOn2;
  logic [15:0]           statusHigh2;
  int                    nFail      = 0;
  int                    checkCount = 0;

  osw_link_if link ();
  osw_link_if chain ();

  osw_host i_osw_host (.clock(clock), .rst(rst), .start(start), .cmdOn(cmdOn), .busy(busy),
    .done(done), .statusHigh(statusHigh), .link(link.host));
  osw_device i_osw_device (.clock(clock), .rst(rst), .link(link.dev), .drainHigh(drainHigh),
    .switchOn(switchOn));
  // Sixteen-bit master on a second link: one device sees a chained frame
  osw_host #(.NBITS(16)) i_osw_host16 (.clock(clock), .rst(rst), .start(start2),
    .cmdOn(cmdOn2), .busy(busy2), .done(done2), .statusHigh(statusHigh2), .link(chain.host));
  osw_device i_osw_device2 (.clock(clock), .rst(rst), .link(chain.dev), .drainHigh(8'hC3),
    .switchOn(switchOn2));
  osw_link_chk i_osw_link_chk (.clock(clock), .rst(rst), .csN(link.csN), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .misoOe(link.misoOe), .misoLine(link.misoLine));

  // ==========================================================
  // Clock, watchdog and wire monitor
  initial begin
    forever #5 clock = ~clock;
  end

  // Eight-bit frames take some 500 cycles, the chained one some 900; far past that something hangs
  initial begin
    #200000;
    nFail++;
    stopTest();
  end

  // Bits as the device samples them, taken at each clock fall
  always @(negedge link.sclk) begin
    if (!link.csN) begin
      mosiBits = {mosiBits[6:0], link.mosi};
      misoBits = {misoBits[6:0], link.misoLine};
    end
  end

  // ==========================================================
  // Compare and closing tasks
  task automatic checkByte(input osw_pkg::osw_word_type got, input osw_pkg::osw_word_type exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    checkByte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic stopTest();
    $display("Checks %0d, mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One frame; drain flips mid-frame to show the snapshot holds
  task automatic runFrame(input osw_pkg::osw_word_type cmd, input osw_pkg::osw_word_type drain);
    osw_pkg::osw_word_type prev;
    int                    n;
    prev = switchOn;
    n = 0;
    cmdOn <= cmd;
    drainHigh <= drain;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
      if (n == 100) begin
        drainHigh <= ~drain;
        checkByte(switchOn, prev);
        checkBit(link.misoOe, 1'b1);
        checkBit(busy, 1'b1);
      end
    end
    if (n >= 2000) begin
      nFail++;
    end
    checkByte(mosiBits, ~cmd);
    checkByte(misoBits, drain);
    checkByte(statusHigh, drain);
    repeat (8) @(posedge clock);
    checkByte(switchOn, cmd);
    checkBit(link.misoOe, 1'b0);
    repeat (26) @(posedge clock);
    checkBit(busy, 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    checkByte(switchOn, 8'h00);
    for (int i = 0; i < 4; i++) begin
      runFrame(cmdTab[i], drainTab[i]);
    end
    // Reset in mid-run, then a frame must still reload fresh status
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    checkByte(switchOn, 8'h00);
    repeat (4) @(posedge clock);
    runFrame(8'h81, 8'h7E);
    // Chained frame: first eight bits come back out behind the status
    cmdOn2 <= 16'h5A3C;
    start2 <= 1'b1;
    @(posedge clock);
    start2 <= 1'b0;
    n = 0;
    while (done2 !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 4000) begin
      nFail++;
    end
    checkByte(statusHigh2[15:8], 8'hC3);
    checkByte(statusHigh2[7:0], 8'hA5);
    repeat (8) @(posedge clock);
    checkByte(switchOn2, 8'h3C);
    checkBit(busy2, 1'b1);
    stopTest();
  end
endmodule

// >>> verification/osw_link_chk.sv
// Concurrent checks on the serial link between the two ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps

module osw_link_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic misoLine
);
  logic [7:0] quietCnt;
  logic [3:0] fallCnt;
  logic       csPrev;
  logic       sclkPrev;

  // ==========================================================
  // Helper counters
  // Cycles since any select or serial clock edge; saturates so long idles never wrap
  always_ff @(posedge clock) begin
    csPrev   <= csN;
    sclkPrev <= sclk;
    if (rst || csN != csPrev || sclk != sclkPrev) begin
      quietCnt <= 8'h00;
    end else if (quietCnt != 8'hFF) begin
      quietCnt <= quietCnt + 8'h01;
    end
    if (rst || csN) begin
      fallCnt <= 4'h0;
    end else if (sclkPrev && !sclk) begin
      fallCnt <= fallCnt + 4'h1;
    end
  end

  // ==========================================================
  // Link properties, all in the system clock domain
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_oe_on_select: assert property (!csN |-> misoOe)
    else $error("serial output not driven while selected");
  a_oe_off_idle: assert property (csN |-> !misoOe)
    else $error("serial output driven while deselected");
  a_line_follows: assert property (misoOe |-> misoLine == miso)
    else $error("wire level differs from driven bit");
  a_sclk_low_edge: assert property ($changed(csN) |-> !sclk && !$past(sclk))
    else $error("select moved with serial clock high");
  a_sclk_idle_low: assert property (csN |-> !sclk)
    else $error("serial clock high while deselected");
  a_miso_on_rise: assert property (!csN && !$past(csN, 5) && $changed(miso) |-> $rose(sclk))
    else $error("serial output changed away from clock rise");
  a_frame_eight: assert property ($rose(csN) |-> fallCnt == 4'h8)
    else $error("frame did not carry eight bits");
  a_rise_spacing: assert property ($rose(sclk) && !csN |-> quietCnt >= 8'd23)
    else $error("serial clock rose too soon");
  a_lag_time: assert property ($rose(csN) |-> quietCnt >= 8'd23)
    else $error("select rose too soon after last bit");
  a_mosi_held: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("command bit moved while clock high");
endmodule
